/* design/crm_arith_flags.sv */
module crm_arith_flags
  import crm_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire logic               rst_por_i,
  input  wire logic               rst_wdt_i,
  input  wire logic               rst_sleep_i,
  input  wire logic               wr_i,
  input  wire logic [ARITH_W-1:0] wdata_i,
  input  wire logic               alu_we_i,
  input  wire logic [ARITH_W-1:0] alu_flags_i,
  output logic      [FLAG_W-1:0]  flags_o
);

  typedef struct packed {
    logic               timeout;
    logic               power_down;
    logic [ARITH_W-1:0] arith;
  } crm_flags_s;

  crm_flags_s s_reg;
  crm_flags_s s_next;

  always_comb begin
    s_next = s_reg;
    if (!rst_n_i) begin
      if (rst_por_i) begin
        s_next = FLAGS_POR;
      end else begin
        s_next.timeout    = ~rst_wdt_i;
        s_next.power_down = ~rst_sleep_i;
      end
    end else if (alu_we_i) begin
      s_next.arith = alu_flags_i;
    end else if (wr_i) begin
      s_next.arith = wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    s_reg <= s_next;
  end

  assign flags_o = s_reg;

endmodule

/* design/crm_data_ram.sv */
module crm_data_ram
  import crm_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 we_i,
  input  wire logic [RAM_IDX_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  input  wire logic [RAM_IDX_W-1:0] raddr_i,
  output logic      [DATA_W-1:0]    rdata_o
);

  logic [DATA_W-1:0] mem [RAM_DEPTH];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule

/* design/crm_pkg.sv */
package crm_pkg;

  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 12;
  localparam int OFF_W     = 7;
  localparam int BANK_W    = 5;
  localparam int LATCH_W   = 7;
  localparam int PC_W      = 15;
  localparam int FLAG_W    = 5;
  localparam int ARITH_W   = 3;
  localparam int IRQF_W    = 3;
  localparam int RAM_DEPTH = 96;
  localparam int RAM_IDX_W = 7;
  localparam int PADDR_W   = 14;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [ADDR_W-1:0] IDX_INDIRECT_PORT_0 = 12'hf80;
  localparam logic [ADDR_W-1:0] IDX_INDIRECT_PORT_1 = 12'hf81;
  localparam logic [ADDR_W-1:0] IDX_PC_LOW_BYTE     = 12'hf82;
  localparam logic [ADDR_W-1:0] IDX_ARITH_FLAGS     = 12'hf83;
  localparam logic [ADDR_W-1:0] IDX_PTR0_LOW        = 12'hf84;
  localparam logic [ADDR_W-1:0] IDX_PTR0_HIGH       = 12'hf85;
  localparam logic [ADDR_W-1:0] IDX_PTR1_LOW        = 12'hf86;
  localparam logic [ADDR_W-1:0] IDX_PTR1_HIGH       = 12'hf87;
  localparam logic [ADDR_W-1:0] IDX_BANK_SELECT     = 12'hf88;
  localparam logic [ADDR_W-1:0] IDX_ACCUMULATOR     = 12'h009;
  localparam logic [ADDR_W-1:0] IDX_PC_HIGH_LATCH   = 12'h00a;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CONTROL     = 12'h00b;

  // Bank offsets of the unmapped gap and of general purpose RAM
  localparam logic [OFF_W-1:0]  UNIMP_LO_OFF   = 7'h0c;
  localparam logic [OFF_W-1:0]  RAM_BASE_OFF   = 7'h20;
  localparam logic [OFF_W-1:0]  RAM_COMMON_OFF = 7'h70;
  localparam logic [BANK_W-1:0] RAM_HOME_BANK  = 5'h00;

  // Values after reset
  localparam logic [DATA_W-1:0]  BYTE_RST   = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST  = 7'h00;
  localparam logic [BANK_W-1:0]  BANK_RST   = 5'h00;
  localparam logic [PC_W-1:0]    PC_RST     = 15'h0000;
  localparam logic [FLAG_W-1:0]  FLAGS_POR  = 5'h18;
  localparam logic [31:0]        WORD_ZERO  = 32'h0000_0000;

  // Flag and control bit positions
  localparam int FLAG_TIMEOUT    = 4;
  localparam int FLAG_POWER_DOWN = 3;
  localparam int IRQ_GLOBAL_EN   = 7;
  localparam int IRQ_PERIPH_EN   = 6;

endpackage

/* design/crm_register_mirror.sv */
// The APB register port was left to the implementer.
module crm_register_mirror
  import crm_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire logic               rst_por_i,
  input  wire logic               rst_wdt_i,
  input  wire logic               rst_sleep_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               alu_flags_we_i,
  input  wire logic [ARITH_W-1:0] alu_flags_i,
  input  wire logic [IRQF_W-1:0]  irq_flag_set_i,
  output logic      [PC_W-1:0]    pc_o,
  output logic                    pc_load_o,
  output logic      [DATA_W-1:0]  accumulator_o,
  output logic      [BANK_W-1:0]  bank_select_o,
  output logic      [DATA_W-1:0]  irq_control_o,
  output logic      [FLAG_W-1:0]  arith_flags_o
);

  typedef struct packed {
    logic [DATA_W-1:0]  accumulator;
    logic [LATCH_W-1:0] pc_high_latch;
    logic [DATA_W-1:0]  irq_control;
    logic [DATA_W-1:0]  ptr0_low;
    logic [DATA_W-1:0]  ptr0_high;
    logic [DATA_W-1:0]  ptr1_low;
    logic [DATA_W-1:0]  ptr1_high;
    logic [BANK_W-1:0]  bank_select;
    logic [PC_W-1:0]    pc;
    logic               pc_load;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } crm_state_s;

  crm_state_s s_reg;
  crm_state_s s_next;

  function automatic logic is_port(input logic [OFF_W-1:0] off);
    is_port = (off == IDX_INDIRECT_PORT_0[OFF_W-1:0]) || (off == IDX_INDIRECT_PORT_1[OFF_W-1:0]);
  endfunction

  function automatic logic ram_hit(input logic [ADDR_W-1:0] addr);
    ram_hit = (addr[OFF_W-1:0] >= RAM_COMMON_OFF) ||
              ((addr[ADDR_W-1:OFF_W] == RAM_HOME_BANK) && (addr[OFF_W-1:0] >= RAM_BASE_OFF));
  endfunction

  function automatic logic [RAM_IDX_W-1:0] ram_index(input logic [ADDR_W-1:0] addr);
    ram_index = addr[OFF_W-1:0] - RAM_BASE_OFF;
  endfunction

  logic [ADDR_W-1:0]    daddr;
  logic [OFF_W-1:0]     off;
  logic                 via_ptr0;
  logic                 via_ptr1;
  logic [ADDR_W-1:0]    tgt;
  logic [OFF_W-1:0]     tgt_off;
  logic                 tgt_void;
  logic                 acc_phase;
  logic                 wr_commit;
  logic [DATA_W-1:0]    wbyte;
  logic [DATA_W-1:0]    rd_byte;
  logic [DATA_W-1:0]    ram_rdata;
  logic                 ram_we;
  logic                 flags_wr;
  logic [FLAG_W-1:0]    flags;

  assign daddr     = paddr_i[PADDR_W-1:2];
  assign off       = daddr[OFF_W-1:0];
  assign wbyte     = pwdata_i[DATA_W-1:0];
  assign acc_phase = psel_i && penable_i;
  assign wr_commit = acc_phase && pwrite_i && s_reg.pready;

  assign via_ptr0 = (off == IDX_INDIRECT_PORT_0[OFF_W-1:0]);
  assign via_ptr1 = (off == IDX_INDIRECT_PORT_1[OFF_W-1:0]);
  assign tgt      = via_ptr0 ? {s_reg.ptr0_high[ADDR_W-DATA_W-1:0], s_reg.ptr0_low} :
                    via_ptr1 ? {s_reg.ptr1_high[ADDR_W-DATA_W-1:0], s_reg.ptr1_low} : daddr;
  assign tgt_off  = tgt[OFF_W-1:0];
  assign tgt_void = is_port(tgt_off);

  always_comb begin
    rd_byte = BYTE_RST;
    if (!tgt_void) begin
      case (tgt_off)
        IDX_PC_LOW_BYTE[OFF_W-1:0]:   rd_byte = s_reg.pc[DATA_W-1:0];
        IDX_ARITH_FLAGS[OFF_W-1:0]:   rd_byte = {{(DATA_W-FLAG_W){1'b0}}, flags};
        IDX_PTR0_LOW[OFF_W-1:0]:      rd_byte = s_reg.ptr0_low;
        IDX_PTR0_HIGH[OFF_W-1:0]:     rd_byte = s_reg.ptr0_high;
        IDX_PTR1_LOW[OFF_W-1:0]:      rd_byte = s_reg.ptr1_low;
        IDX_PTR1_HIGH[OFF_W-1:0]:     rd_byte = s_reg.ptr1_high;
        IDX_BANK_SELECT[OFF_W-1:0]:   rd_byte = {{(DATA_W-BANK_W){1'b0}}, s_reg.bank_select};
        IDX_ACCUMULATOR[OFF_W-1:0]:   rd_byte = s_reg.accumulator;
        IDX_PC_HIGH_LATCH[OFF_W-1:0]: rd_byte = {1'b0, s_reg.pc_high_latch};
        IDX_IRQ_CONTROL[OFF_W-1:0]:   rd_byte = s_reg.irq_control;
        default: begin
          if (ram_hit(tgt)) begin
            rd_byte = ram_rdata;
          end
        end
      endcase
    end
  end

  assign ram_we   = wr_commit && !tgt_void && ram_hit(tgt) && !is_port(tgt_off) &&
                    (tgt_off >= RAM_BASE_OFF);
  assign flags_wr = wr_commit && !tgt_void && (tgt_off == IDX_ARITH_FLAGS[OFF_W-1:0]);

  crm_data_ram u_ram (
    .clock_i (clock_i),
    .we_i    (ram_we),
    .waddr_i (ram_index(tgt)),
    .wdata_i (wbyte),
    .raddr_i (ram_index(tgt)),
    .rdata_o (ram_rdata)
  );

  crm_arith_flags u_flags (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .rst_por_i   (rst_por_i),
    .rst_wdt_i   (rst_wdt_i),
    .rst_sleep_i (rst_sleep_i),
    .wr_i        (flags_wr),
    .wdata_i     (wbyte[ARITH_W-1:0]),
    .alu_we_i    (alu_flags_we_i),
    .alu_flags_i (alu_flags_i),
    .flags_o     (flags)
  );

  always_comb begin
    s_next         = s_reg;
    s_next.pc_load = 1'b0;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    // Hardware flag sets win over a clearing write
    s_next.irq_control[IRQF_W-1:0] = s_reg.irq_control[IRQF_W-1:0] | irq_flag_set_i;
    if (!rst_n_i) begin
      s_next.pc_high_latch = LATCH_RST;
      s_next.pc            = PC_RST;
      s_next.bank_select   = BANK_RST;
      s_next.irq_control   = BYTE_RST;
      s_next.ptr0_high     = BYTE_RST;
      s_next.ptr1_high     = BYTE_RST;
      s_next.prdata        = WORD_ZERO;
      if (rst_por_i) begin
        s_next.ptr0_low    = BYTE_RST;
        s_next.ptr1_low    = BYTE_RST;
        s_next.accumulator = BYTE_RST;
      end
    end else if (acc_phase && !s_reg.pready) begin
      s_next.pready = 1'b1;
      if (!pwrite_i) begin
        s_next.prdata = {24'h00_0000, rd_byte};
      end
    end else if (wr_commit && !tgt_void) begin
      case (tgt_off)
        IDX_PC_LOW_BYTE[OFF_W-1:0]: begin
          s_next.pc      = {s_reg.pc_high_latch, wbyte};
          s_next.pc_load = 1'b1;
        end
        IDX_PTR0_LOW[OFF_W-1:0]:      s_next.ptr0_low      = wbyte;
        IDX_PTR0_HIGH[OFF_W-1:0]:     s_next.ptr0_high     = wbyte;
        IDX_PTR1_LOW[OFF_W-1:0]:      s_next.ptr1_low      = wbyte;
        IDX_PTR1_HIGH[OFF_W-1:0]:     s_next.ptr1_high     = wbyte;
        IDX_BANK_SELECT[OFF_W-1:0]:   s_next.bank_select   = wbyte[BANK_W-1:0];
        IDX_ACCUMULATOR[OFF_W-1:0]:   s_next.accumulator   = wbyte;
        IDX_PC_HIGH_LATCH[OFF_W-1:0]: s_next.pc_high_latch = wbyte[LATCH_W-1:0];
        IDX_IRQ_CONTROL[OFF_W-1:0]: begin
          s_next.irq_control = {wbyte[DATA_W-1:IRQF_W], wbyte[IRQF_W-1:0] | irq_flag_set_i};
        end
        default: begin
          s_next.pc_load = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    s_reg <= s_next;
  end

  assign prdata_o      = s_reg.prdata;
  assign pready_o      = s_reg.pready;
  assign pslverr_o     = s_reg.pslverr;
  assign pc_o          = s_reg.pc;
  assign pc_load_o     = s_reg.pc_load;
  assign accumulator_o = s_reg.accumulator;
  assign bank_select_o = s_reg.bank_select;
  assign irq_control_o = s_reg.irq_control;
  assign arith_flags_o = flags;

  property p_bank_mirror;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_commit && off == IDX_ACCUMULATOR[OFF_W-1:0]) |=> (accumulator_o == $past(wbyte)) && !pready_o;
  endproperty
  a_bank_mirror: assert property (p_bank_mirror) else $error("accumulator not written from this bank");

  property p_latch_load;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_commit && off == IDX_PC_LOW_BYTE[OFF_W-1:0])
      |=> pc_load_o && (pc_o == {$past(s_reg.pc_high_latch), $past(wbyte)}) ##1 !pc_load_o;
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("counter load did not use the latch");

  property p_ptr_por;
    @(posedge clock_i)
    (!rst_n_i && rst_por_i) |=> (s_reg.ptr0_low == BYTE_RST) && (s_reg.ptr0_high == BYTE_RST) &&
                                (s_reg.ptr1_low == BYTE_RST) && (s_reg.ptr1_high == BYTE_RST);
  endproperty
  a_ptr_por: assert property (p_ptr_por) else $error("pointer not cleared on power-on reset");

  property p_unimp_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o && off >= UNIMP_LO_OFF && off < RAM_BASE_OFF)
      |=> pready_o && (prdata_o == WORD_ZERO);
  endproperty
  a_unimp_zero: assert property (p_unimp_zero) else $error("unimplemented location read nonzero");

  property p_latch_top_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o && off == IDX_PC_HIGH_LATCH[OFF_W-1:0]) |=> prdata_o[DATA_W-1] == 1'b0;
  endproperty
  a_latch_top_zero: assert property (p_latch_top_zero) else $error("latch top bit read nonzero");

  property p_por_flags;
    @(posedge clock_i)
    (!rst_n_i && rst_por_i) |=> arith_flags_o == FLAGS_POR;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_warm_flags;
    @(posedge clock_i)
    (!rst_n_i && !rst_por_i) |=> (arith_flags_o[ARITH_W-1:0] == $past(arith_flags_o[ARITH_W-1:0])) &&
                                 (arith_flags_o[FLAG_TIMEOUT] == !$past(rst_wdt_i)) &&
                                 (arith_flags_o[FLAG_POWER_DOWN] == !$past(rst_sleep_i));
  endproperty
  a_warm_flags: assert property (p_warm_flags) else $error("flags wrong after other reset");

  property p_indirect_read;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o && via_ptr0 && tgt_off == IDX_ACCUMULATOR[OFF_W-1:0])
      |=> prdata_o[DATA_W-1:0] == $past(s_reg.accumulator);
  endproperty
  a_indirect_read: assert property (p_indirect_read) else $error("indirect read missed its target");

  property p_indirect_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_commit && via_ptr1 && tgt_off == IDX_BANK_SELECT[OFF_W-1:0])
      |=> bank_select_o == $past(wbyte[BANK_W-1:0]);
  endproperty
  a_indirect_write: assert property (p_indirect_write) else $error("indirect write missed its target");

  property p_bank_direct;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_commit && off == IDX_BANK_SELECT[OFF_W-1:0]) |=> bank_select_o == $past(wbyte[BANK_W-1:0]);
  endproperty
  a_bank_direct: assert property (p_bank_direct) else $error("bank select not written from this bank");

  property p_latch_reset;
    @(posedge clock_i)
    !rst_n_i |=> (s_reg.pc_high_latch == LATCH_RST) && (pc_o == PC_RST) && !pc_load_o;
  endproperty
  a_latch_reset: assert property (p_latch_reset) else $error("latch or counter not cleared by reset");

  property p_latch_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_commit && off == IDX_PC_HIGH_LATCH[OFF_W-1:0]) |=> s_reg.pc_high_latch == $past(wbyte[LATCH_W-1:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  property p_load_source;
    @(posedge clock_i) disable iff (!rst_n_i)
    pc_load_o |-> $past(wr_commit) && ($past(tgt_off) == IDX_PC_LOW_BYTE[OFF_W-1:0]);
  endproperty
  a_load_source: assert property (p_load_source) else $error("counter loaded without a low byte write");

  property p_high_ptr_reset;
    @(posedge clock_i)
    !rst_n_i |=> (s_reg.ptr0_high == BYTE_RST) && (s_reg.ptr1_high == BYTE_RST);
  endproperty
  a_high_ptr_reset: assert property (p_high_ptr_reset) else $error("high pointer not cleared by reset");

  property p_warm_ptr_keep;
    @(posedge clock_i)
    (!rst_n_i && !rst_por_i) |=> (s_reg.ptr0_low == $past(s_reg.ptr0_low)) &&
                                 (s_reg.ptr1_low == $past(s_reg.ptr1_low)) &&
                                 (accumulator_o == $past(accumulator_o));
  endproperty
  a_warm_ptr_keep: assert property (p_warm_ptr_keep) else $error("low pointer lost on other reset");

  property p_read_upper_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o) |=> pready_o && (prdata_o[31:DATA_W] == 24'h00_0000);
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("read word upper bits nonzero");

  property p_bank_top_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o && off == IDX_BANK_SELECT[OFF_W-1:0])
      |=> prdata_o[DATA_W-1:BANK_W] == 3'b000;
  endproperty
  a_bank_top_zero: assert property (p_bank_top_zero) else $error("bank select top bits read nonzero");

  property p_flags_top_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o && off == IDX_ARITH_FLAGS[OFF_W-1:0])
      |=> prdata_o[DATA_W-1:FLAG_W] == 3'b000;
  endproperty
  a_flags_top_zero: assert property (p_flags_top_zero) else $error("flag register top bits read nonzero");

  property p_power_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    rst_n_i |=> $stable(arith_flags_o[FLAG_TIMEOUT:FLAG_POWER_DOWN]);
  endproperty
  a_power_hold: assert property (p_power_hold) else $error("power flags changed outside reset");

  property p_port_void;
    @(posedge clock_i) disable iff (!rst_n_i)
    (acc_phase && !pwrite_i && !pready_o && (via_ptr0 || via_ptr1) && is_port(tgt_off))
      |=> prdata_o == WORD_ZERO;
  endproperty
  a_port_void: assert property (p_port_void) else $error("port through port read nonzero");

endmodule

/* tb/crm_register_mirror_tb_top.sv */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module crm_register_mirror_tb_top
  import crm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clock;
  logic               rst_n;
  logic               rst_por;
  logic               rst_wdt;
  logic               rst_sleep;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               alu_we;
  logic [ARITH_W-1:0] alu_flags;
  logic [IRQF_W-1:0]  irq_set;
  logic [PC_W-1:0]    pc;
  logic               pc_load;
  logic [DATA_W-1:0]  acc;
  logic [BANK_W-1:0]  bank;
  logic [DATA_W-1:0]  irq_ctl;
  logic [FLAG_W-1:0]  flags;
  int                 fail_count;
  int                 total_checks;
  int                 cycles;
  logic [31:0]        exp_q[$];
  logic [31:0]        exp_w;
  logic [7:0]         v[12];
  logic [7:0]         r;
  logic [PC_W-1:0]    pc_q[$];
  logic [PC_W-1:0]    exp_p;

  crm_register_mirror u_crm_register_mirror (
    .clock_i        (clock),
    .rst_n_i        (rst_n),
    .rst_por_i      (rst_por),
    .rst_wdt_i      (rst_wdt),
    .rst_sleep_i    (rst_sleep),
    .psel_i         (psel),
    .penable_i      (penable),
    .pwrite_i       (pwrite),
    .paddr_i        (paddr),
    .pwdata_i       (pwdata),
    .prdata_o       (prdata),
    .pready_o       (pready),
    .pslverr_o      (pslverr),
    .alu_flags_we_i (alu_we),
    .alu_flags_i    (alu_flags),
    .irq_flag_set_i (irq_set),
    .pc_o           (pc),
    .pc_load_o      (pc_load),
    .accumulator_o  (acc),
    .bank_select_o  (bank),
    .irq_control_o  (irq_ctl),
    .arith_flags_o  (flags)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Read results taken at the completing edge
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite) begin
      exp_w = exp_q.pop_front();
      `CHK(prdata, exp_w)
      `CHK(pslverr, 1'b0)
    end
    if (pc_load) begin
      exp_p = pc_q.pop_front();
      `CHK(pc, exp_p)
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'($urandom()), d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] x);
    exp_q.push_back({24'h00_0000, x});
    apb(1'b0, idx, 8'h00);
  endtask

  function automatic logic [11:0] ix(input int b, input int o);
    return {5'(b), 7'(o)};
  endfunction

  task automatic do_reset(input logic por, input logic wdt, input logic slp);
    rst_n <= 1'b0;
    rst_por <= por;
    rst_wdt <= wdt;
    rst_sleep <= slp;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask

  initial begin
    int bl[3];
    bl = '{0, 17, 31};
    {rst_n, rst_por, rst_wdt, rst_sleep, psel, penable, pwrite} = 7'h00;
    paddr = '0;
    pwdata = '0;
    alu_we = 1'b0;
    alu_flags = '0;
    irq_set = '0;
    void'($urandom(32'h883d));
    do_reset(1'b1, 1'b0, 1'b0);
    // power-on values in several banks, gap reads zero
    for (int b = 0; b < 3; b++) begin
      for (int o = 0; o < 14; o++) begin
        rd(ix(bl[b], (o == 13) ? 31 : o), (o == 3) ? 8'h18 : 8'h00);
      end
    end
    // write in one bank, read in another
    for (int o = 4; o < 12; o++) begin
      r = 8'($urandom());
      v[o] = r & ((o == 8) ? 8'h1f : (o == 10) ? 8'h7f : 8'hff);
      apb(1'b1, ix($urandom_range(31, 0), o), r);
      rd(ix($urandom_range(31, 0), o), v[o]);
    end
    `CHK(acc, v[9])
    `CHK(bank, v[8][4:0])
    `CHK(irq_ctl, v[11])
    apb(1'b1, ix(3, 3), 8'hff);
    rd(ix(29, 3), 8'h1f);
    apb(1'b1, ix(5, 12), 8'hff);
    rd(ix(5, 12), 8'h00);
    r = 8'($urandom());
    pc_q.push_back({v[10][6:0], r});
    apb(1'b1, ix(12, 2), r);
    `CHK(pc, {v[10][6:0], r})
    rd(ix(31, 2), r);
    apb(1'b1, ix(0, 5), 8'h00);
    apb(1'b1, ix(7, 4), 8'h25);
    r = 8'($urandom());
    apb(1'b1, ix(0, 0), r);
    rd(ix(0, 'h25), r);
    rd(ix(20, 0), r);
    apb(1'b1, ix(0, 7), 8'hfb);
    apb(1'b1, ix(0, 6), 8'h75);
    r = 8'($urandom());
    apb(1'b1, ix(0, 1), r);
    rd(ix(0, 'h75), r);
    rd(ix(9, 'h75), r);
    rd(ix(30, 1), r);
    alu_we <= 1'b1;
    alu_flags <= 3'b010;
    irq_set <= 3'b101;
    @(posedge clock);
    alu_we <= 1'b0;
    irq_set <= 3'b000;
    @(posedge clock);
    rd(ix(1, 3), 8'h1a);
    rd(ix(2, 11), v[11] | 8'h05);
    // other resets keep arithmetic flags, report cause
    apb(1'b1, ix(4, 3), 8'h05);
    do_reset(1'b0, 1'b1, 1'b0);
    `CHK(flags, 5'h0d)
    rd(ix(0, 3), 8'h0d);
    rd(ix(0, 9), v[9]);
    rd(ix(0, 4), 8'h25);
    rd(ix(0, 5), 8'h00);
    rd(ix(0, 10), 8'h00);
    rd(ix(0, 11), 8'h00);
    do_reset(1'b0, 1'b0, 1'b1);
    rd(ix(0, 3), 8'h15);
    rd(ix(0, 6), 8'h75);
    do_reset(1'b1, 1'b0, 1'b0);
    rd(ix(0, 3), 8'h18);
    rd(ix(0, 9), 8'h00);
    rd(ix(0, 6), 8'h00);
    `CHK(flags, FLAGS_POR)
    r = 8'($urandom());
    apb(1'b1, ix(6, 9), r);
    apb(1'b1, ix(0, 4), 8'h09);
    rd(ix(3, 0), r);
    apb(1'b1, ix(0, 6), 8'h88);
    apb(1'b1, ix(0, 1), r);
    `CHK(bank, r[4:0])
    rd(ix(5, 8), {3'b000, r[4:0]});
    @(posedge clock);
    `CHK(exp_q.size(), 0)
    `CHK(pc_q.size(), 0)
    end_sim();
  end

endmodule
